/* File: pkg/mdau_pkg.sv */
// Function
// RULE1 - multiply, add and shift finish in one clock; 16-bit divide takes five clocks
// RULE2 - operands A and B are 16 bits; accumulator, result, prior result are 32 bits
// RULE3 - all arithmetic is two's-complement signed
// RULE4 - software sets the engine enable bit before touching any unit register
// RULE5 - software selects register page 1 before reaching the unit registers
// RULE6 - a 32-bit barrel shifter scales the sum in the same cycle
// RULE7 - manual capture trigger copies result to prior result in manual mode; reads 0
// RULE8 - capture mode 0 captures on every A low write, 1 only on trigger
// RULE9 - overflow capture enable stores the result when a 32-bit overflow occurs
// RULE10 - read stored select shows prior result instead of current result
// RULE11 - adder source picks zero, accumulator or prior; code 11 adds concatenated operands
// RULE12 - product select picks A*B, A*A, or A*prior low half
// RULE13 - divider mode zeroes multiplier inputs; multiplier mode feeds divider 0 over 1
// RULE14 - write-only clear field clears chosen operands or flags; reads as 0
// RULE15 - interrupt enable bit gates the unit interrupt in divider mode
// RULE16 - range error flag set on zero divisor or 0x8000 divided by 0xFFFF
// RULE17 - 16-bit overflow flag set on carry out of bit 15 or bit 31
// RULE18 - 32-bit overflow flag set when the signed result exceeds 32 bits
// RULE19 - bit 3 of the secondary configuration register reads as 0
// RULE20 - result follows operand registers combinationally with no start command
// RULE21 - software limits operands to 15 bits for unsigned multiplication
// RULE22 - 32-bit overflow can raise the interrupt; overflow flags stay set until cleared
// RULE23 - writing B low through the divisor alias loads it and enters divider mode
// RULE24 - after division the upper half holds quotient, lower half remainder
// RULE25 - for 32-bit addition A is the upper half and B the lower half
// RULE26 - the barrel shifter is bypassed during division
// RULE27 - software waits five clocks after a division setup before reading
`default_nettype none
package mdau_pkg;
    // register addresses on page 1
    localparam logic [7:0] ADDR_MULT_LO = 8'hA2;
    localparam logic [7:0] ADDR_MULT_HI = 8'hA3;
    localparam logic [7:0] ADDR_ACC0 = 8'hA4;
    localparam logic [7:0] ADDR_DIV_ALIAS = 8'hB1;
    localparam logic [7:0] ADDR_MCAND_LO = 8'hB2;
    localparam logic [7:0] ADDR_MCAND_HI = 8'hB3;
    localparam logic [7:0] ADDR_RES0 = 8'hB4;
    localparam logic [7:0] ADDR_CFG1 = 8'hC2;
    localparam logic [7:0] ADDR_CFG2 = 8'hC3;
    // field positions
    localparam int CFG1_TRIG_BIT = 7;
    localparam int CFG1_MODE_BIT = 6;
    localparam int CFG2_IRQEN_BIT = 4;
    localparam int CFG2_CLR_LSB = 5;
    localparam int SHIFT_W = 5;
    // reset values
    localparam logic [7:0] CFG1_RESET = 8'h00;
    localparam logic [15:0] OPND_RESET = 16'h0000;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    // divider
    localparam logic [2:0] DIV_CYCLES = 3'h5;
    localparam logic [15:0] DIV_IDLE_DIVIDEND = 16'h0000;
    localparam logic [15:0] DIV_IDLE_DIVISOR = 16'h0001;
    localparam logic [15:0] DIV_MIN_NEG = 16'h8000;
    localparam logic [15:0] DIV_MINUS_ONE = 16'hFFFF;
    // operand clear commands
    localparam logic [2:0] CLR_NONE = 3'h0;
    localparam logic [2:0] CLR_MULT = 3'h1;
    localparam logic [2:0] CLR_MCAND = 3'h2;
    localparam logic [2:0] CLR_ACC = 3'h3;
    localparam logic [2:0] CLR_PRIOR = 3'h4;
    localparam logic [2:0] CLR_ALL = 3'h5;
    localparam logic [2:0] CLR_FLAGS = 3'h6;
    // adder source and product select codes
    localparam logic [1:0] ADD_ZERO = 2'h0;
    localparam logic [1:0] ADD_ACC = 2'h1;
    localparam logic [1:0] ADD_PRIOR = 2'h2;
    localparam logic [1:0] ADD_CONCAT = 2'h3;
    localparam logic [1:0] PROD_AB = 2'h0;
    localparam logic [1:0] PROD_SQUARE = 2'h1;
    localparam logic [1:0] PROD_PRIOR = 2'h2;
    localparam logic [1:0] PROD_AB_ALT = 2'h3;

    // register-bus request from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } mdau_sfr_req_t;

    // primary configuration register layout
    typedef struct packed {
        logic manualCaptureTrigger;
        logic captureModeSelect;
        logic overflowCaptureEnable;
        logic readStoredSelect;
        logic [1:0] adderSourceSelect;
        logic [1:0] productSelect;
    } mdau_cfg1_t;
endpackage
`default_nettype wire

/* File: rtl/mdau_divider.sv */
`default_nettype none
module mdau_divider (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic start,
    input wire logic [15:0] dividend,
    input wire logic [15:0] divisor,
    output logic [31:0] result_q,
    output logic done_q
);
    import mdau_pkg::*;

    logic [2:0] cnt_q, cnt_d;
    logic [31:0] result_d;
    logic done_d;
    logic badRange;

    // countdown and result latch
    always_comb begin
        cnt_d = cnt_q;
        result_d = result_q;
        done_d = done_q;
        badRange = (divisor == 16'h0000) ||
                   (dividend == DIV_MIN_NEG && divisor == DIV_MINUS_ONE);
        if (start) begin
            cnt_d = DIV_CYCLES; // [RULE1]
            done_d = 1'b0;
        end else if (cnt_q != 3'h0) begin
            cnt_d = cnt_q - 3'h1;
            if (cnt_q == 3'h1) begin
                done_d = 1'b1;
                if (badRange) begin
                    result_d = {16'h0000, dividend}; // quotient forced to 0
                end else begin
                    // quotient high, remainder low [RULE24] [RULE3]
                    result_d = {16'($signed(dividend) / $signed(divisor)),
                                16'($signed(dividend) % $signed(divisor))};
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 3'h0;
            result_q <= WORD_RESET;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            result_q <= result_d;
            done_q <= done_d;
        end
    end

    property p_div_five;
        @(posedge clk_sys) disable iff (!nrst)
        (start ##1 (!start)[*5]) |=> done_q;
    endproperty
    a_div_five: assert property (p_div_five) else $error("divide not done in 5"); // [RULE1]

    property p_div_not_early;
        @(posedge clk_sys) disable iff (!nrst)
        start |=> !done_q [*4];
    endproperty
    a_div_not_early: assert property (p_div_not_early) else $error("divide done early"); // [RULE1]

    c_div_done: cover property (@(posedge clk_sys) disable iff (!nrst) start ##6 done_q);
endmodule
`default_nettype wire

/* File: rtl/mdau_top.sv */
`default_nettype none
module mdau_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire mdau_pkg::mdau_sfr_req_t sfrReq,
    input wire logic pageIsOne,
    input wire logic engineEnable,
    input wire logic shiftLeft,
    input wire logic [mdau_pkg::SHIFT_W-1:0] shiftAmt,
    output logic [7:0] sfrRdData_q,
    output logic mathIrq_q
);
    import mdau_pkg::*;

    // operand, configuration and flag state
    logic [15:0] opA_q, opA_d, opB_q, opB_d;
    logic [31:0] acc_q, acc_d, prior_q, prior_d;
    mdau_cfg1_t cfg1_q, cfg1_d;
    logic irqEn_q, irqEn_d;
    logic divMode_q, divMode_d;
    logic ovf16_q, ovf16_d, ovf32_q, ovf32_d;
    logic rangeErr_q, rangeErr_d;
    logic ov32Seen_q, ov32Seen_d;
    logic [7:0] rdData_d;
    logic irq_d;

    // datapath nets
    logic [15:0] mulA, mulB, dividendIn, divisorIn;
    logic [31:0] product, addInA, addInB, shifted, curResult, shownResult;
    logic [32:0] sumSigned, sumCarry;
    logic [16:0] lowSum;
    logic ov16, ov32, rangeCond;
    logic [31:0] divResult;
    logic divDone, divStart;
    logic [2:0] clrCmd;
    logic manualCap, autoCap, ovCap, clrFlags;

    // register access only on page 1 with the engine enabled
    function automatic logic wrHit(input mdau_sfr_req_t r, input logic en,
                                   input logic [7:0] a);
        return r.wr && en && (r.addr == a);
    endfunction

    function automatic logic [15:0] setByte(input logic [15:0] v, input logic hi,
                                            input logic [7:0] b);
        logic [15:0] o;
        o = v;
        if (hi) begin
            o[15:8] = b;
        end else begin
            o[7:0] = b;
        end
        return o;
    endfunction

    logic busOk;
    assign busOk = pageIsOne && engineEnable; // [RULE4] [RULE5]

    // arithmetic datapath, purely combinational from the operand registers
    always_comb begin
        mulA = divMode_q ? 16'h0000 : opA_q; // [RULE13]
        unique case (cfg1_q.productSelect) // [RULE12]
            PROD_AB, PROD_AB_ALT: mulB = opB_q;
            PROD_SQUARE: mulB = opA_q;
            PROD_PRIOR: mulB = prior_q[15:0];
        endcase
        if (divMode_q) begin
            mulB = 16'h0000; // [RULE13]
        end
        // operands sign-extended first so the product is formed at full 32-bit width
        product = {{16{mulA[15]}}, mulA} * {{16{mulB[15]}}, mulB}; // [RULE3] [RULE2]
        // concatenated A:B addend, A on top [RULE25] [RULE11]
        addInA = (cfg1_q.adderSourceSelect == ADD_CONCAT) ? {opA_q, opB_q} : product;
        unique case (cfg1_q.adderSourceSelect) // [RULE11]
            ADD_ZERO: addInB = WORD_RESET;
            ADD_ACC, ADD_CONCAT: addInB = acc_q;
            ADD_PRIOR: addInB = prior_q;
        endcase
        sumSigned = {addInA[31], addInA} + {addInB[31], addInB};
        sumCarry = {1'b0, addInA} + {1'b0, addInB};
        lowSum = {1'b0, addInA[15:0]} + {1'b0, addInB[15:0]};
        ov32 = sumSigned[32] ^ sumSigned[31]; // [RULE18]
        ov16 = lowSum[16] | sumCarry[32]; // [RULE17]
        // barrel shifter in the same cycle [RULE6] [RULE1]
        if (shiftLeft) begin
            shifted = sumSigned[31:0] << shiftAmt;
        end else begin
            shifted = 32'($signed(sumSigned[31:0]) >>> shiftAmt);
        end
        curResult = divMode_q ? divResult : shifted; // [RULE26] [RULE20]
        shownResult = cfg1_q.readStoredSelect ? prior_q : curResult; // [RULE10]
        dividendIn = divMode_q ? opA_q : DIV_IDLE_DIVIDEND; // [RULE13]
        divisorIn = divMode_q ? opB_q : DIV_IDLE_DIVISOR; // [RULE13]
        rangeCond = (divisorIn == 16'h0000) ||
                    (dividendIn == DIV_MIN_NEG && divisorIn == DIV_MINUS_ONE); // [RULE16]
    end

    mdau_divider i_mdau_divider (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(divStart),
        .dividend(dividendIn),
        .divisor(divisorIn),
        .result_q(divResult),
        .done_q(divDone)
    );

    // next values of the register file, captures and flags
    always_comb begin
        opA_d = opA_q;
        opB_d = opB_q;
        acc_d = acc_q;
        prior_d = prior_q;
        cfg1_d = cfg1_q;
        irqEn_d = irqEn_q;
        divMode_d = divMode_q;
        clrCmd = CLR_NONE;
        manualCap = 1'b0;
        divStart = 1'b0;
        if (wrHit(sfrReq, busOk, ADDR_MULT_LO)) begin
            opA_d = setByte(opA_q, 1'b0, sfrReq.data);
        end
        if (wrHit(sfrReq, busOk, ADDR_MULT_HI)) begin
            opA_d = setByte(opA_q, 1'b1, sfrReq.data);
        end
        if (wrHit(sfrReq, busOk, ADDR_MCAND_LO)) begin
            opB_d = setByte(opB_q, 1'b0, sfrReq.data);
            divMode_d = 1'b0;
        end
        if (wrHit(sfrReq, busOk, ADDR_DIV_ALIAS)) begin
            opB_d = setByte(opB_q, 1'b0, sfrReq.data); // [RULE23]
            divMode_d = 1'b1; // [RULE23]
        end
        if (wrHit(sfrReq, busOk, ADDR_MCAND_HI)) begin
            opB_d = setByte(opB_q, 1'b1, sfrReq.data);
        end
        for (int i = 0; i < 4; i++) begin
            if (wrHit(sfrReq, busOk, ADDR_ACC0 + 8'(i))) begin
                acc_d[8*i +: 8] = sfrReq.data;
            end
        end
        if (wrHit(sfrReq, busOk, ADDR_CFG1)) begin
            cfg1_d = mdau_cfg1_t'(sfrReq.data);
            cfg1_d.manualCaptureTrigger = 1'b0; // [RULE7]
            manualCap = sfrReq.data[CFG1_TRIG_BIT] && sfrReq.data[CFG1_MODE_BIT]; // [RULE7]
        end
        if (wrHit(sfrReq, busOk, ADDR_CFG2)) begin
            irqEn_d = sfrReq.data[CFG2_IRQEN_BIT]; // [RULE15]
            clrCmd = sfrReq.data[CFG2_CLR_LSB +: 3]; // [RULE14]
        end
        // prior-result capture sources [RULE8] [RULE9]
        autoCap = wrHit(sfrReq, busOk, ADDR_MULT_LO) && !cfg1_q.captureModeSelect;
        ovCap = cfg1_q.overflowCaptureEnable && ov32 && !ov32Seen_q;
        if (autoCap || manualCap || ovCap) begin
            prior_d = curResult;
        end
        // operand clear commands [RULE14]
        unique case (clrCmd)
            CLR_MULT: opA_d = OPND_RESET;
            CLR_MCAND: opB_d = OPND_RESET;
            CLR_ACC: acc_d = WORD_RESET;
            CLR_PRIOR: prior_d = WORD_RESET;
            CLR_ALL: begin
                opA_d = OPND_RESET;
                opB_d = OPND_RESET;
                acc_d = WORD_RESET;
                prior_d = WORD_RESET;
                divMode_d = 1'b0;
            end
            CLR_NONE, CLR_FLAGS: ;
            default: ;
        endcase
        clrFlags = (clrCmd == CLR_ALL) || (clrCmd == CLR_FLAGS);
        // in divider mode, writes to A low, A high, B high or the divisor alias restart the divide
        if (divMode_d && (wrHit(sfrReq, busOk, ADDR_MULT_LO) ||
                          wrHit(sfrReq, busOk, ADDR_MULT_HI) ||
                          wrHit(sfrReq, busOk, ADDR_DIV_ALIAS) ||
                          wrHit(sfrReq, busOk, ADDR_MCAND_HI))) begin
            divStart = 1'b1;
        end
        // sticky overflow flags, a new event wins over a clear [RULE22]
        ovf16_d = (ovf16_q && !clrFlags) || ov16; // [RULE17]
        ovf32_d = (ovf32_q && !clrFlags) || ov32; // [RULE18]
        ov32Seen_d = ov32;
        rangeErr_d = rangeCond; // [RULE16]
        irq_d = irqEn_q && (ovf32_q || (divMode_q && divDone)); // [RULE15] [RULE22]
    end

    // read port, answered on the edge after the read strobe
    always_comb begin
        rdData_d = 8'h00;
        if (sfrReq.rd && busOk) begin
            unique case (sfrReq.addr)
                ADDR_MULT_LO: rdData_d = opA_q[7:0];
                ADDR_MULT_HI: rdData_d = opA_q[15:8];
                ADDR_DIV_ALIAS, ADDR_MCAND_LO: rdData_d = opB_q[7:0];
                ADDR_MCAND_HI: rdData_d = opB_q[15:8];
                ADDR_CFG1: rdData_d = {1'b0, cfg1_q[CFG1_MODE_BIT:0]}; // [RULE7]
                // clear field and bit 3 read zero [RULE14] [RULE19]
                ADDR_CFG2: rdData_d = {3'h0, irqEn_q, 1'b0, rangeErr_q, ovf16_q, ovf32_q};
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (sfrReq.addr == ADDR_ACC0 + 8'(i)) begin
                            rdData_d = acc_q[8*i +: 8];
                        end
                        if (sfrReq.addr == ADDR_RES0 + 8'(i)) begin
                            rdData_d = shownResult[8*i +: 8]; // [RULE10]
                        end
                    end
                end
            endcase
        end
    end

    // all state registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            opA_q <= OPND_RESET;
            opB_q <= OPND_RESET;
            acc_q <= WORD_RESET;
            prior_q <= WORD_RESET;
            cfg1_q <= mdau_cfg1_t'(CFG1_RESET);
            irqEn_q <= 1'b0;
            divMode_q <= 1'b0;
            ovf16_q <= 1'b0;
            ovf32_q <= 1'b0;
            rangeErr_q <= 1'b0;
            ov32Seen_q <= 1'b0;
            sfrRdData_q <= 8'h00;
            mathIrq_q <= 1'b0;
        end else begin
            opA_q <= opA_d;
            opB_q <= opB_d;
            acc_q <= acc_d;
            prior_q <= prior_d;
            cfg1_q <= cfg1_d;
            irqEn_q <= irqEn_d;
            divMode_q <= divMode_d;
            ovf16_q <= ovf16_d;
            ovf32_q <= ovf32_d;
            rangeErr_q <= rangeErr_d;
            ov32Seen_q <= ov32Seen_d;
            sfrRdData_q <= rdData_d;
            mathIrq_q <= irq_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    property p_cfg1_trig_reads_zero;
        (sfrReq.rd && busOk && sfrReq.addr == ADDR_CFG1) |=> !sfrRdData_q[CFG1_TRIG_BIT];
    endproperty
    a_cfg1_trig_reads_zero: assert property (p_cfg1_trig_reads_zero) else $error("trig read 1"); // [RULE7]

    property p_cfg2_clr_reads_zero;
        (sfrReq.rd && busOk && sfrReq.addr == ADDR_CFG2) |=> sfrRdData_q[7:5] == 3'h0;
    endproperty
    a_cfg2_clr_reads_zero: assert property (p_cfg2_clr_reads_zero) else $error("clr read"); // [RULE14]

    property p_cfg2_bit3_zero;
        (sfrReq.rd && busOk && sfrReq.addr == ADDR_CFG2) |=> !sfrRdData_q[3];
    endproperty
    a_cfg2_bit3_zero: assert property (p_cfg2_bit3_zero) else $error("bit 3 read 1"); // [RULE19]

    property p_auto_capture;
        (wrHit(sfrReq, busOk, ADDR_MULT_LO) && !cfg1_q.captureModeSelect)
            |=> prior_q == $past(curResult);
    endproperty
    a_auto_capture: assert property (p_auto_capture) else $error("auto capture missed"); // [RULE8]

    property p_alias_enters_div;
        wrHit(sfrReq, busOk, ADDR_DIV_ALIAS)
            |=> divMode_q && opB_q[7:0] == $past(sfrReq.data);
    endproperty
    a_alias_enters_div: assert property (p_alias_enters_div) else $error("alias failed"); // [RULE23]

    property p_mult_mode_div_inputs;
        !divMode_q |-> dividendIn == DIV_IDLE_DIVIDEND && divisorIn == DIV_IDLE_DIVISOR;
    endproperty
    a_mult_mode_div_inputs: assert property (p_mult_mode_div_inputs) else $error("div in"); // [RULE13]

    property p_range_flag;
        (divMode_q && opB_q == 16'h0000) |=> rangeErr_q;
    endproperty
    a_range_flag: assert property (p_range_flag) else $error("range flag not set"); // [RULE16]

    property p_ovf32_sticky;
        (ov32 ##1 (clrCmd != CLR_ALL && clrCmd != CLR_FLAGS)[*3]) |-> ovf32_q;
    endproperty
    a_ovf32_sticky: assert property (p_ovf32_sticky) else $error("ov32 flag lost"); // [RULE18]

    property p_clear_all;
        wrHit(sfrReq, busOk, ADDR_CFG2) && sfrReq.data[7:5] == CLR_ALL
            |=> opA_q == OPND_RESET && acc_q == WORD_RESET && !divMode_q;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("clear all failed"); // [RULE14]

    property p_read_stored;
        (sfrReq.rd && busOk && sfrReq.addr == ADDR_RES0 && cfg1_q.readStoredSelect)
            |=> sfrRdData_q == $past(prior_q[7:0]);
    endproperty
    a_read_stored: assert property (p_read_stored) else $error("stored read wrong"); // [RULE10]

    c_manual_capture: cover property (manualCap);
    c_ov32_event: cover property (ov32 ##1 ovf32_q);
    c_irq: cover property (mathIrq_q);
endmodule
`default_nettype wire

/* File: bench/mdau_core_model.sv */
`default_nettype none
module mdau_core_model (
    input wire logic clk_sys,
    output mdau_pkg::mdau_sfr_req_t sfrReq,
    output logic pageIsOne,
    output logic engineEnable
);
    timeunit 1ns;
    timeprecision 1ps;
    import mdau_pkg::*;

    // bus idle, page 1 selected and unit enabled from time zero
    initial begin
        sfrReq = '0;
        pageIsOne = 1'h1;
        engineEnable = 1'h1;
    end

    // page and enable levels; refusal scenarios drop one of them
    task automatic reach(input logic pg, input logic en);
        @(negedge clk_sys);
        pageIsOne <= pg;
        engineEnable <= en;
    endtask

    // one access held over one rising edge, then released with lines inverted
    task automatic access(input logic w, input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk_sys);
        sfrReq <= '{wr: w, rd: !w, addr: ad, data: d};
        @(negedge clk_sys);
        sfrReq <= '{wr: 1'h0, rd: 1'h0, addr: ~ad, data: ~d};
    endtask
endmodule
`default_nettype wire

/* File: bench/mdau_top_test.sv */
`default_nettype none
module mdau_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mdau_pkg::*;
    logic clk_sys = 1'h0, nrst = 1'h0, shiftLeft = 1'h0, irqEn = 1'h0, divMode = 1'h0;
    logic [SHIFT_W-1:0] shiftAmt = '0;
    mdau_sfr_req_t sfrReq;
    logic pageIsOne, engineEnable, mathIrq;
    logic [7:0] rdData, cfg1 = '0;
    logic [15:0] opA = '0, opB = '0;
    logic [31:0] opC = '0, prior = '0;
    logic [7:0] expQ[$];
    int errCount = 0, samplesChecked = 0, cycles = 0;

    mdau_top i_mdau_top (.clk_sys(clk_sys), .nrst(nrst), .sfrReq(sfrReq),
        .pageIsOne(pageIsOne), .engineEnable(engineEnable), .shiftLeft(shiftLeft),
        .shiftAmt(shiftAmt), .sfrRdData_q(rdData), .mathIrq_q(mathIrq));
    mdau_core_model i_mdau_core_model (.clk_sys(clk_sys), .sfrReq(sfrReq),
        .pageIsOne(pageIsOne), .engineEnable(engineEnable));

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    // hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errCount++;
            testDone();
        end
    end

    // read data lands on the read edge; compare at the next falling edge with oldest note
    always @(posedge clk_sys) begin
        if (sfrReq.rd === 1'h1) begin
            @(negedge clk_sys);
            check(rdData, expQ.pop_front());
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] e);
        samplesChecked++;
        if (got !== e) begin
            errCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask

    task automatic testDone();
        if (errCount == 0 && samplesChecked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // expected result: product, adder source, then barrel shift
    function automatic logic [31:0] calcRes();
        logic signed [31:0] p, s;
        logic [15:0] m;
        m = (cfg1[1:0] == PROD_SQUARE) ? opA : (cfg1[1:0] == PROD_PRIOR) ? prior[15:0] : opB;
        p = $signed(opA) * $signed(m);
        case (cfg1[3:2])
            ADD_ZERO: s = p;
            ADD_PRIOR: s = p + prior;
            ADD_CONCAT: s = {opA, opB} + opC;
            default: s = p + opC;
        endcase
        return shiftLeft ? s <<< shiftAmt : s >>> shiftAmt;
    endfunction

    function automatic logic [31:0] divRes(input logic [15:0] dd, input logic [15:0] dv);
        if (dv == 16'h0000 || (dd == DIV_MIN_NEG && dv == DIV_MINUS_ONE))
            return {16'h0000, dd};
        return {16'($signed(dd) / $signed(dv)), 16'($signed(dd) % $signed(dv))};
    endfunction

    // range flag follows the divider inputs, which are forced to 0 over 1 outside divider mode
    function automatic logic [7:0] c3(input logic [1:0] ov);
        logic rng;
        rng = divMode && (opB == 16'h0000 || (opA == DIV_MIN_NEG && opB == DIV_MINUS_ONE));
        return {3'h0, irqEn, 1'h0, rng, ov};
    endfunction

    // register write, mirrored into the expected state
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        if (ad == ADDR_MULT_LO && !cfg1[CFG1_MODE_BIT])
            prior = calcRes();
        if (ad == ADDR_CFG1 && d[CFG1_TRIG_BIT] && d[CFG1_MODE_BIT])
            prior = calcRes();
        case (ad)
            ADDR_MULT_LO: opA[7:0] = d;
            ADDR_MULT_HI: opA[15:8] = d;
            ADDR_MCAND_LO, ADDR_DIV_ALIAS: begin
                opB[7:0] = d;
                divMode = (ad == ADDR_DIV_ALIAS);
            end
            ADDR_MCAND_HI: opB[15:8] = d;
            ADDR_CFG1: cfg1 = {1'h0, d[6:0]};
            ADDR_CFG2: begin
                irqEn = d[CFG2_IRQEN_BIT];
                if (d[7:5] == CLR_MULT || d[7:5] == CLR_ALL) opA = '0;
                if (d[7:5] == CLR_MCAND || d[7:5] == CLR_ALL) opB = '0;
                if (d[7:5] == CLR_ACC || d[7:5] == CLR_ALL) opC = '0;
                if (d[7:5] == CLR_PRIOR || d[7:5] == CLR_ALL) prior = '0;
                if (d[7:5] == CLR_ALL) divMode = 1'h0;
            end
            default: if (ad[7:2] == ADDR_ACC0[7:2]) opC[8*ad[1:0] +: 8] = d;
        endcase
        i_mdau_core_model.access(1'h1, ad, d);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        expQ.push_back(e);
        i_mdau_core_model.access(1'h0, ad, 8'h00);
    endtask

    task automatic rd32(input logic [31:0] e);
        for (int i = 0; i < 4; i++)
            rd(ADDR_RES0 + 8'(i), e[8*i +: 8]);
    endtask

    task automatic setOps(input logic [15:0] a, input logic [15:0] b, input logic [31:0] c);
        wr(ADDR_MULT_LO, a[7:0]);
        wr(ADDR_MULT_HI, a[15:8]);
        wr(ADDR_MCAND_LO, b[7:0]);
        wr(ADDR_MCAND_HI, b[15:8]);
        for (int i = 0; i < 4; i++)
            wr(ADDR_ACC0 + 8'(i), c[8*i +: 8]);
    endtask

    task automatic rdOps();
        rd(ADDR_MULT_LO, opA[7:0]);
        rd(ADDR_MULT_HI, opA[15:8]);
        rd(ADDR_MCAND_LO, opB[7:0]);
        rd(ADDR_MCAND_HI, opB[15:8]);
        for (int i = 0; i < 4; i++)
            rd(ADDR_ACC0 + 8'(i), opC[8*i +: 8]);
    endtask

    task automatic irqIs(input logic e);
        repeat (2) @(negedge clk_sys);
        check({7'h00, mathIrq}, {7'h00, e});
    endtask

    // main sequence
    initial begin
        void'($urandom(32'hC945));
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'h1;
        rd(ADDR_CFG1, 8'h00);
        rd(ADDR_CFG2, c3(2'h0));
        rd32(32'h0000_0000);
        for (int k = 0; k < 16; k++) begin
            logic [15:0] msk;
            msk = k[0] ? 16'h7FFF : 16'hFFFF; // unsigned use keeps 15 bits
            @(negedge clk_sys);
            shiftLeft = 1'($urandom);
            shiftAmt = SHIFT_W'($urandom);
            setOps(16'($urandom) & msk, 16'($urandom) & msk, $urandom);
            wr(ADDR_CFG1, 8'hC0 | 8'(k));
            rd(ADDR_CFG1, cfg1);
            rd32(calcRes());
            wr(ADDR_CFG1, cfg1 | 8'h10);
            rd32(prior);
        end
        wr(ADDR_CFG1, 8'h10);
        wr(ADDR_MULT_LO, 8'($urandom));
        rd32(prior);
        wr(ADDR_CFG1, 8'h40);
        for (int code = 1; code < 7; code++) begin
            setOps(16'($urandom), 16'($urandom), $urandom);
            wr(ADDR_CFG1, 8'hC0);
            wr(ADDR_CFG2, 8'(code) << 5);
            rdOps();
            if (code >= 5) rd(ADDR_CFG2, c3(2'h0));
            wr(ADDR_CFG1, 8'h50);
            rd32(prior);
        end
        @(negedge clk_sys);
        shiftLeft = 1'h0;
        shiftAmt = '0;
        wr(ADDR_CFG2, 8'hA0);
        wr(ADDR_CFG1, 8'h64);
        setOps(16'h0001, 16'h0001, 32'h7FFF_FFFF);
        prior = 32'h8000_0000;
        wr(ADDR_CFG2, 8'h10);
        rd(ADDR_CFG2, c3(2'h3));
        irqIs(1'h1);
        wr(ADDR_CFG1, 8'h74);
        rd32(prior);
        setOps(16'h0001, 16'h0001, 32'h0000_0000);
        wr(ADDR_CFG2, 8'hD0);
        rd(ADDR_CFG2, c3(2'h0));
        irqIs(1'h0);
        i_mdau_core_model.reach(1'h0, 1'h1);
        i_mdau_core_model.access(1'h1, ADDR_MULT_LO, 8'h5A);
        rd(ADDR_MULT_LO, 8'h00);
        i_mdau_core_model.reach(1'h1, 1'h0);
        rd(ADDR_MULT_LO, 8'h00);
        i_mdau_core_model.reach(1'h1, 1'h1);
        wr(8'hA1, 8'hFF);
        rd(8'hA1, 8'h00);
        rd(ADDR_MULT_LO, opA[7:0]);
        wr(ADDR_CFG2, 8'h00);
        wr(ADDR_CFG1, 8'h40);
        @(negedge clk_sys);
        shiftLeft = 1'h1; // shifter must stay out of the divide path
        shiftAmt = SHIFT_W'(3);
        for (int k = 0; k < 4; k++) begin
            logic [15:0] dd, dv;
            dd = (k == 1) ? DIV_MIN_NEG : (k == 3) ? 16'hFFF9 : 16'($urandom);
            dv = (k == 1) ? DIV_MINUS_ONE : (k == 2) ? 16'h0000 : 16'($urandom);
            if (k == 3) dv = 16'h0002;
            wr(ADDR_MULT_LO, dd[7:0]);
            wr(ADDR_MULT_HI, dd[15:8]);
            wr(ADDR_MCAND_HI, dv[15:8]);
            wr(ADDR_DIV_ALIAS, dv[7:0]);
            repeat (4) @(negedge clk_sys);
            rd32(divRes(dd, dv));
            rd(ADDR_CFG2, c3(2'h0));
        end
        wr(ADDR_CFG2, 8'h10);
        irqIs(1'h1);
        repeat (4) @(negedge clk_sys);
        testDone();
    end
endmodule
`default_nettype wire
